/* File: inc/hub_charging_polarity_config_regs.vh */
// constants for the hub charging and line-polarity configuration bank
// assumes byte-wide register accesses from a configuration loader on clk
//
// How it works
// - bit 7 of charging config reads zero, writes are ignored.
// - divider select mirrors otp unless charge unlock bit is one.
// - one write may set charge unlock and divider select together.
// - polarity bit takes the strap pin level when reset releases; 1 is active high.
// - eeprom mode loads polarity from eeprom; smbus mode lets host overwrite.
// - automatic charging uses acp2 when select is 0, acp3 when 1.
// - bits 3:2 of charging config are plain read-back storage.
// - unconnected upstream: auto mode when disable is 0, else dcp only.
// - connected upstream gives cdp on every charging port regardless.
// - five swap bits mirror otp unless polarity unlock bit is one.
// - one write may set polarity unlock and swap bits, applied at once.
// - swap bits 4..1 steer downstream ports 4..1; one swaps dm and dp.
// - swap bit 0 steers the upstream port the same way.
// - polarity register bits 6:5 read zero, writes are ignored.
// - vdo value spans four byte offsets 0x0c to 0x0f.
// - vdo is write-only, reads return zero, loadable by eeprom or host.
// - charging config sits at 0x0a, resets zero except strap polarity bit and otp divider select.
`ifndef HUB_CHARGING_POLARITY_CONFIG_REGS_VH
`define HUB_CHARGING_POLARITY_CONFIG_REGS_VH

// byte offsets
`define CHG_CFG_OFFSET 8'h0a
`define LINE_POL_OFFSET 8'h0b
`define VDO_OFFSET_B0 8'h0c
`define VDO_OFFSET_B1 8'h0d
`define VDO_OFFSET_B2 8'h0e
`define VDO_OFFSET_B3 8'h0f

// charging config field positions
`define CHG_UNLOCK_BIT 6
`define CHG_POL_BIT 5
`define CHG_HICUR_BIT 4
`define CHG_SPARE_HI 3
`define CHG_SPARE_LO 2
`define CHG_AUTODIS_BIT 1

// polarity register field positions
`define POL_UNLOCK_BIT 7
`define POL_SWAP_HI 4
`define POL_SWAP_LO 0

// reset values
`define CHG_CFG_RESET 8'h00
`define LINE_POL_RESET 8'h00
`define VDO_RESET 32'h00001c45

// strap capture: cycles after release for the two-stage synchroniser to settle
`define STRAP_SETTLE_CYCLES 2'h2

// per-port charge mode encoding
`define MODE_OFF 2'h0
`define MODE_CDP 2'h1
`define MODE_DCP 2'h2
`define MODE_AUTO 2'h3

`endif

/* File: rtl/line_swap_port.v */
// one usb 2.0 port's dm/dp steering between core and pads
// assumes pad inputs are asynchronous and pad outputs are resolved outside
`timescale 1ns/10ps
module line_swap_port (
    input wire clk,
    input wire arst_n,
    input wire swap,
    input wire core_dp_out,
    input wire core_dm_out,
    input wire core_oe,
    input wire pad_dp_in,
    input wire pad_dm_in,
    output reg core_dp_in,
    output reg core_dm_in,
    output reg pad_dp_out,
    output reg pad_dm_out,
    output reg pad_oe
);

    reg dp_meta_q;
    reg dm_meta_q;
    reg dp_sync_q;
    reg dm_sync_q;

    // two-stage synchronisers on the pad levels, only stage two reads stage one
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dp_meta_q <= 1'b0;
            dm_meta_q <= 1'b0;
            dp_sync_q <= 1'b0;
            dm_sync_q <= 1'b0;
        end else begin
            dp_meta_q <= pad_dp_in;
            dm_meta_q <= pad_dm_in;
            dp_sync_q <= dp_meta_q;
            dm_sync_q <= dm_meta_q;
        end
    end

    // both directions swap so attach and line-state logic see nominal wiring
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            core_dp_in <= 1'b0;
            core_dm_in <= 1'b0;
            pad_dp_out <= 1'b0;
            pad_dm_out <= 1'b0;
            pad_oe <= 1'b0;
        end else begin
            core_dp_in <= swap ? dm_sync_q : dp_sync_q;
            core_dm_in <= swap ? dp_sync_q : dm_sync_q;
            pad_dp_out <= swap ? core_dm_out : core_dp_out;
            pad_dm_out <= swap ? core_dp_out : core_dm_out;
            pad_oe <= core_oe;
        end
    end

endmodule

/* File: rtl/hub_charging_polarity_config_regs.v */
// charging configuration, line polarity and billboard vdo registers of the hub
// assumes the smbus slave or eeprom loader presents byte writes and reads on clk,
// otp values and port status are already in the clk domain
`timescale 1ns/10ps
`include "hub_charging_polarity_config_regs.vh"
module hub_charging_polarity_config_regs (
    input wire clk,
    input wire arst_n,
    // byte register port shared by the smbus host and the eeprom loader
    input wire reg_wr_en,
    input wire reg_rd_en,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr_from_eeprom,
    output reg [7:0] reg_rdata,
    output reg reg_rd_valid,
    // configuration source: 1 = eeprom loading, 0 = smbus slave
    input wire eeprom_mode,
    // strap pin, asynchronous
    input wire power_polarity_strap_pin,
    // one-time-programmable defaults
    input wire otp_high_current_divider_select,
    input wire [4:0] otp_port_line_swap_bits,
    // charging context
    input wire upstream_connected,
    input wire [3:0] charge_port_enable,
    input wire [3:0] port_power_request,
    // charging results
    output reg [3:0] port_power_switch_output,
    output reg power_switch_polarity,
    output reg high_current_divider_select,
    output reg acp3_select,
    output reg auto_charge_mode_disable,
    output reg [7:0] port_charge_mode,
    output reg [3:0] spare_config_bits,
    // effective swap bits, bit 0 upstream
    output reg [4:0] port_line_swap_bits,
    output reg [31:0] billboard_alt_mode_vdo_value,
    // usb 2.0 core and pad side, bit 0 upstream, 1..4 downstream
    input wire [4:0] core_dp_out,
    input wire [4:0] core_dm_out,
    input wire [4:0] core_oe,
    input wire [4:0] pad_dp_in,
    input wire [4:0] pad_dm_in,
    output wire [4:0] core_dp_in,
    output wire [4:0] core_dm_in,
    output wire [4:0] pad_dp_out,
    output wire [4:0] pad_dm_out,
    output wire [4:0] pad_oe
);

    // stored fields
    reg charge_feature_write_unlock_q;
    reg charge_feature_write_unlock_d;
    reg pol_q;
    reg pol_d;
    reg hicur_q;
    reg hicur_d;
    reg [1:0] spare_q;
    reg [1:0] spare_d;
    reg autodis_q;
    reg autodis_d;
    reg polarity_write_unlock_q;
    reg polarity_write_unlock_d;
    reg [4:0] swap_q;
    reg [4:0] swap_d;
    reg [31:0] vdo_q;
    reg [31:0] vdo_d;

    // strap capture
    reg strap_meta_q;
    reg strap_sync_q;
    reg [1:0] strap_cnt_q;
    reg [1:0] strap_state_q;

    // strap capture states, one-hot
    localparam [1:0] strap_fill = 2'b01;
    localparam [1:0] strap_held = 2'b10;
    wire strap_done = (strap_state_q == strap_held);

    // reset images, so reset branches assign nothing but constants
    localparam [7:0] chg_reset_val = `CHG_CFG_RESET;
    localparam [7:0] pol_reset_val = `LINE_POL_RESET;

    // read mux ahead of the answer flop
    reg [7:0] rd_mux;

    // decode
    wire wr_chg = reg_wr_en && (reg_addr == `CHG_CFG_OFFSET);
    wire wr_pol = reg_wr_en && (reg_addr == `LINE_POL_OFFSET);
    wire wr_vdo0 = reg_wr_en && (reg_addr == `VDO_OFFSET_B0);
    wire wr_vdo1 = reg_wr_en && (reg_addr == `VDO_OFFSET_B1);
    wire wr_vdo2 = reg_wr_en && (reg_addr == `VDO_OFFSET_B2);
    wire wr_vdo3 = reg_wr_en && (reg_addr == `VDO_OFFSET_B3);

    // polarity bit source follows the configuration mode
    wire pol_wr_allowed = eeprom_mode ? reg_wr_from_eeprom : !reg_wr_from_eeprom;

    // effective values seen by reads and by the charging logic
    wire hicur_eff = charge_feature_write_unlock_q ? hicur_q
                                                   : otp_high_current_divider_select;
    wire [4:0] swap_eff = polarity_write_unlock_q ? swap_q
                                                  : otp_port_line_swap_bits;

    // the strap is a pin: two flops before anything looks at it
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            strap_meta_q <= 1'b0;
            strap_sync_q <= 1'b0;
        end else begin
            strap_meta_q <= power_polarity_strap_pin;
            strap_sync_q <= strap_meta_q;
        end
    end

    // wait for the synchroniser to fill before trusting the strap level
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            strap_cnt_q <= 2'h0;
            strap_state_q <= strap_fill;
        end else begin
            case (strap_state_q)
                strap_fill: begin
                    if (strap_cnt_q == `STRAP_SETTLE_CYCLES) begin
                        strap_state_q <= strap_held;
                    end else begin
                        strap_cnt_q <= strap_cnt_q + 2'h1;
                    end
                end
                strap_held: begin
                    strap_state_q <= strap_held;
                end
                default: begin
                    // a lost state recaptures rather than leaving the polarity unknown
                    strap_state_q <= strap_fill;
                end
            endcase
        end
    end

    // charging configuration next state, polarity bit kept apart
    always @* begin
        charge_feature_write_unlock_d = charge_feature_write_unlock_q;
        hicur_d = hicur_q;
        spare_d = spare_q;
        autodis_d = autodis_q;
        if (wr_chg) begin
            // bit 7 and bit 0 have no storage, so writes there vanish
            charge_feature_write_unlock_d = reg_wdata[`CHG_UNLOCK_BIT];
            // new unlock value gates the select in the very same write
            if (reg_wdata[`CHG_UNLOCK_BIT]) begin
                hicur_d = reg_wdata[`CHG_HICUR_BIT];
            end
            spare_d = reg_wdata[`CHG_SPARE_HI:`CHG_SPARE_LO];
            autodis_d = reg_wdata[`CHG_AUTODIS_BIT];
        end
    end

    // polarity bit: strap once after reset, later only writes the mode allows
    always @* begin
        pol_d = pol_q;
        if (!strap_done && (strap_cnt_q == `STRAP_SETTLE_CYCLES)) begin
            pol_d = strap_sync_q;
        end
        if (wr_chg && pol_wr_allowed && strap_done) begin
            pol_d = reg_wdata[`CHG_POL_BIT];
        end
    end

    // polarity register next state
    always @* begin
        polarity_write_unlock_d = polarity_write_unlock_q;
        swap_d = swap_q;
        if (wr_pol) begin
            polarity_write_unlock_d = reg_wdata[`POL_UNLOCK_BIT];
            // bits 6:5 are not stored
            if (reg_wdata[`POL_UNLOCK_BIT]) begin
                swap_d = reg_wdata[`POL_SWAP_HI:`POL_SWAP_LO];
            end
        end
    end

    // vdo bytes, little endian across the four offsets
    always @* begin
        vdo_d = vdo_q;
        if (wr_vdo0) begin
            vdo_d[7:0] = reg_wdata;
        end
        if (wr_vdo1) begin
            vdo_d[15:8] = reg_wdata;
        end
        if (wr_vdo2) begin
            vdo_d[23:16] = reg_wdata;
        end
        if (wr_vdo3) begin
            vdo_d[31:24] = reg_wdata;
        end
    end

    // register storage
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            charge_feature_write_unlock_q <= chg_reset_val[`CHG_UNLOCK_BIT];
            pol_q <= chg_reset_val[`CHG_POL_BIT];
            hicur_q <= chg_reset_val[`CHG_HICUR_BIT];
            spare_q <= chg_reset_val[`CHG_SPARE_HI:`CHG_SPARE_LO];
            autodis_q <= chg_reset_val[`CHG_AUTODIS_BIT];
            polarity_write_unlock_q <= pol_reset_val[`POL_UNLOCK_BIT];
            swap_q <= pol_reset_val[`POL_SWAP_HI:`POL_SWAP_LO];
            vdo_q <= `VDO_RESET;
        end else begin
            charge_feature_write_unlock_q <= charge_feature_write_unlock_d;
            pol_q <= pol_d;
            hicur_q <= hicur_d;
            spare_q <= spare_d;
            autodis_q <= autodis_d;
            polarity_write_unlock_q <= polarity_write_unlock_d;
            swap_q <= swap_d;
            vdo_q <= vdo_d;
        end
    end

    // read mux; vdo and unmapped offsets read zero
    always @* begin
        case (reg_addr)
            `CHG_CFG_OFFSET: begin
                rd_mux = {1'b0, charge_feature_write_unlock_q, pol_q, hicur_eff,
                          spare_q, autodis_q, 1'b0};
            end
            `LINE_POL_OFFSET: begin
                rd_mux = {polarity_write_unlock_q, 2'h0, swap_eff};
            end
            default: begin
                rd_mux = 8'h00;
            end
        endcase
    end

    // read answer one cycle after the request, zero when no answer stands
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd_en;
            reg_rdata <= reg_rd_en ? rd_mux : 8'h00;
        end
    end

    // charging mode per downstream port, one slice per port
    wire [7:0] mode_d;
    genvar c;
    generate
        for (c = 0; c < 4; c = c + 1) begin : g_mode
            reg [1:0] mode_c;
            always @* begin
                if (!charge_port_enable[c]) begin
                    mode_c = `MODE_OFF;
                end else if (upstream_connected) begin
                    mode_c = `MODE_CDP;
                end else if (autodis_q) begin
                    mode_c = `MODE_DCP;
                end else begin
                    mode_c = `MODE_AUTO;
                end
            end
            assign mode_d[2*c +: 2] = mode_c;
        end
    endgenerate

    // power-switch enables; low polarity drives them inverted
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            port_power_switch_output <= 4'h0;
            power_switch_polarity <= 1'b0;
        end else begin
            port_power_switch_output <= pol_q ? port_power_request : ~port_power_request;
            power_switch_polarity <= pol_q;
        end
    end

    // divider select; acp3 only matters while a port is in automatic mode
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            high_current_divider_select <= 1'b0;
            acp3_select <= 1'b0;
        end else begin
            high_current_divider_select <= hicur_eff;
            acp3_select <= hicur_eff;
        end
    end

    // charge mode per port and the disable bit behind it
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            auto_charge_mode_disable <= 1'b0;
            port_charge_mode <= 8'h00;
        end else begin
            auto_charge_mode_disable <= autodis_q;
            port_charge_mode <= mode_d;
        end
    end

    // spare bits mirror; the upper two have no storage behind them
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            spare_config_bits <= 4'h0;
        end else begin
            spare_config_bits <= {2'h0, spare_q};
        end
    end

    // effective swap bits and the vdo value handed to the billboard side
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            port_line_swap_bits <= 5'h00;
            billboard_alt_mode_vdo_value <= `VDO_RESET;
        end else begin
            port_line_swap_bits <= swap_eff;
            billboard_alt_mode_vdo_value <= vdo_q;
        end
    end

    // one steering slice per port, bit 0 upstream
    genvar p;
    generate
        for (p = 0; p < 5; p = p + 1) begin : g_port
            line_swap_port u_swap (
                .clk(clk),
                .arst_n(arst_n),
                .swap(swap_eff[p]),
                .core_dp_out(core_dp_out[p]),
                .core_dm_out(core_dm_out[p]),
                .core_oe(core_oe[p]),
                .pad_dp_in(pad_dp_in[p]),
                .pad_dm_in(pad_dm_in[p]),
                .core_dp_in(core_dp_in[p]),
                .core_dm_in(core_dm_in[p]),
                .pad_dp_out(pad_dp_out[p]),
                .pad_dm_out(pad_dm_out[p]),
                .pad_oe(pad_oe[p])
            );
        end
    endgenerate

endmodule

/* File: test/hub_charging_polarity_config_regs_checker.sv */
// assertions on the register port, charging outputs and dp pad steering of the config bank
// assumes it is bound onto hub_charging_polarity_config_regs, single clock domain
`timescale 1ns/10ps
`include "hub_charging_polarity_config_regs.vh"
module hub_charging_polarity_config_regs_checker (
    input wire clk,
    input wire arst_n,
    input wire reg_rd_en,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_rdata,
    input wire reg_rd_valid,
    input wire upstream_connected,
    input wire [3:0] charge_port_enable,
    input wire [3:0] port_power_request,
    input wire [3:0] port_power_switch_output,
    input wire power_switch_polarity,
    input wire high_current_divider_select,
    input wire acp3_select,
    input wire auto_charge_mode_disable,
    input wire [7:0] port_charge_mode,
    input wire [4:0] port_line_swap_bits,
    input wire [4:0] core_dp_out,
    input wire [4:0] core_dm_out,
    input wire [4:0] pad_dp_out
);
    reg [1:0] warm_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // cycles since release, so $past never looks into reset
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            warm_q <= 2'h0;
        else if (warm_q != 2'h3)
            warm_q <= warm_q + 2'h1;
    end
    // expected per-port charge mode from context and disable bit
    function [7:0] mode_of(input up, input dis, input [3:0] en);
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1)
                mode_of[2*i+:2] = !en[i] ? `MODE_OFF : up ? `MODE_CDP : dis ? `MODE_DCP : `MODE_AUTO;
        end
    endfunction
    a_read_answer: assert property (warm_q != 2'h0 |-> reg_rd_valid == $past(reg_rd_en))
        else $error("read valid not one cycle after read strobe");
    a_rdata_idle: assert property (!reg_rd_valid |-> reg_rdata == 8'h00)
        else $error("read data not zero outside valid");
    a_vdo_unreadable: assert property (reg_rd_en && reg_addr >= `VDO_OFFSET_B0 &&
        reg_addr <= `VDO_OFFSET_B3 |=> reg_rdata == 8'h00) else $error("vdo byte readable");
    a_chg_reserved: assert property (reg_rd_en && reg_addr == `CHG_CFG_OFFSET |=>
        reg_rd_valid && reg_rdata[7] == 1'b0 && reg_rdata[0] == 1'b0)
        else $error("charging config reserved bit not zero");
    a_pol_reserved: assert property (reg_rd_en && reg_addr == `LINE_POL_OFFSET |=>
        reg_rdata[6:5] == 2'h0) else $error("polarity reserved bits not zero");
    a_power_polarity: assert property (warm_q == 2'h3 && $stable(power_switch_polarity) |->
        port_power_switch_output == (power_switch_polarity ? $past(port_power_request)
        : ~$past(port_power_request))) else $error("power switch output polarity wrong");
    a_acp_tracks: assert property (acp3_select == high_current_divider_select)
        else $error("divider mode does not follow select");
    a_charge_mode: assert property (warm_q == 2'h3 && $stable(upstream_connected) &&
        $stable(charge_port_enable) && $stable(auto_charge_mode_disable) |-> port_charge_mode
        == mode_of(upstream_connected, auto_charge_mode_disable, charge_port_enable))
        else $error("charge mode wrong");
    a_line_steer: assert property (warm_q == 2'h3 && $stable(port_line_swap_bits) |->
        pad_dp_out == ((port_line_swap_bits & $past(core_dm_out))
        | (~port_line_swap_bits & $past(core_dp_out)))) else $error("dp pad steering wrong");
endmodule
bind hub_charging_polarity_config_regs hub_charging_polarity_config_regs_checker chk (
    .clk(clk), .arst_n(arst_n), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .upstream_connected(upstream_connected),
    .charge_port_enable(charge_port_enable), .port_power_request(port_power_request),
    .port_power_switch_output(port_power_switch_output),
    .power_switch_polarity(power_switch_polarity),
    .high_current_divider_select(high_current_divider_select), .acp3_select(acp3_select),
    .auto_charge_mode_disable(auto_charge_mode_disable), .port_charge_mode(port_charge_mode),
    .port_line_swap_bits(port_line_swap_bits), .core_dp_out(core_dp_out),
    .core_dm_out(core_dm_out), .pad_dp_out(pad_dp_out));

/* File: test/config_loader_model.sv */
// behavioural smbus host or eeprom loader issuing byte accesses to the config bank
// assumes strobes are taken at posedge and reads answer one edge later
`timescale 1ns/10ps
module config_loader_model (
    input wire clk,
    input wire [7:0] reg_rdata,
    input wire reg_rd_valid,
    output reg reg_wr_en,
    output reg reg_rd_en,
    output reg [7:0] reg_addr,
    output reg [7:0] reg_wdata,
    output reg reg_wr_from_eeprom
);
    // idle at time zero so no strobe precedes the first access
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr_from_eeprom = 1'b0;
    end
    // one byte write; address and data are scrambled afterwards, not left helpfully stale
    task wr(input [7:0] a, input [7:0] d, input ee);
        begin
            @(negedge clk);
            reg_addr = a;
            reg_wdata = d;
            reg_wr_from_eeprom = ee;
            reg_wr_en = 1'b1;
            @(negedge clk);
            reg_wr_en = 1'b0;
            reg_addr = ~a;
            reg_wdata = ~d;
        end
    endtask
    // one byte read; ok stays low when no answer comes within four cycles
    task rd(input [7:0] a, output [7:0] d, output ok);
        integer n;
        begin
            ok = 1'b0;
            d = 8'h00;
            @(negedge clk);
            reg_addr = a;
            reg_rd_en = 1'b1;
            @(negedge clk);
            reg_rd_en = 1'b0;
            reg_addr = ~a;
            for (n = 0; n < 4 && !ok; n = n + 1) begin
                if (reg_rd_valid === 1'b1) begin
                    d = reg_rdata;
                    ok = 1'b1;
                end else
                    @(negedge clk);
            end
        end
    endtask
endmodule

/* File: test/hub_charging_polarity_config_regs_test.sv */
// self-checking bench for the charging and line polarity configuration bank
// assumes the loader model owns the register port and the bench drives all else
`timescale 1ns/10ps
`include "hub_charging_polarity_config_regs.vh"
module hub_charging_polarity_config_regs_test;
    reg clk = 1'b0;
    reg arst_n = 1'b0;
    reg ee_mode = 1'b0;
    reg strap = 1'b1;
    reg up = 1'b0;
    reg [3:0] en = 4'hb;
    reg [3:0] req = 4'h5;
    reg [4:0] cdp = 5'h1f;
    reg [4:0] cdm = 5'h00;
    reg [4:0] coe = 5'h13;
    reg otp_hicur = 1'b1;
    reg [4:0] otp_swap = 5'h15;
    reg [4:0] pdp = 5'h1f;
    reg [4:0] pdm = 5'h00;
    wire wr_en, rd_en, from_ee, rd_valid, pol, hicur, acp3, autodis;
    wire [7:0] addr, wdata, rdata, mode;
    wire [3:0] pwr, spare;
    wire [4:0] swap, c_dp_in, c_dm_in, p_dp_out, p_dm_out, p_oe;
    wire [31:0] vdo;
    integer n_fail = 0;
    integer n_compared = 0;
    integer i;
    reg [7:0] got;
    reg ok;
    reg [24:0] rows [0:8];
    // free-running 125 MHz clock
    initial begin
        forever #4 clk = ~clk;
    end
    config_loader_model loader (.clk(clk), .reg_rdata(rdata), .reg_rd_valid(rd_valid),
        .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr_from_eeprom(from_ee));
    hub_charging_polarity_config_regs DUT (.clk(clk), .arst_n(arst_n), .reg_wr_en(wr_en),
        .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata), .reg_wr_from_eeprom(from_ee),
        .reg_rdata(rdata), .reg_rd_valid(rd_valid), .eeprom_mode(ee_mode),
        .power_polarity_strap_pin(strap), .otp_high_current_divider_select(otp_hicur),
        .otp_port_line_swap_bits(otp_swap), .upstream_connected(up), .charge_port_enable(en),
        .port_power_request(req), .port_power_switch_output(pwr), .power_switch_polarity(pol),
        .high_current_divider_select(hicur), .acp3_select(acp3),
        .auto_charge_mode_disable(autodis), .port_charge_mode(mode), .spare_config_bits(spare),
        .port_line_swap_bits(swap), .billboard_alt_mode_vdo_value(vdo), .core_dp_out(cdp),
        .core_dm_out(cdm), .core_oe(coe), .pad_dp_in(pdp), .pad_dm_in(pdm), .core_dp_in(c_dp_in),
        .core_dm_in(c_dm_in), .pad_dp_out(p_dp_out), .pad_dm_out(p_dm_out), .pad_oe(p_oe));
    task finish_test;
        begin
            $display("compared %0d mismatches %0d", n_compared, n_fail);
            if (n_fail == 0 && n_compared > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task cmp(input [31:0] g, input [31:0] e);
        begin
            n_compared = n_compared + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask
    // a read with no answer in bounds ends the run as a mismatch
    task check_read(input [7:0] a, input [7:0] e);
        begin
            loader.rd(a, got, ok);
            if (!ok) begin
                n_fail = n_fail + 1;
                $display("ERROR t=%0t no read answer at %h", $time, a);
                finish_test;
            end else
                cmp({24'h000000, got}, {24'h000000, e});
        end
    endtask
    // rows: address, write data, eeprom source, expected read-back
    initial begin
        rows[0] = {8'h0a, 8'hff, 1'b0, 8'h7e};
        rows[1] = {8'h0a, 8'h0c, 1'b0, 8'h1c};
        rows[2] = {8'h0a, 8'h40, 1'b1, 8'h40};
        rows[3] = {8'h0b, 8'hff, 1'b0, 8'h9f};
        rows[4] = {8'h0b, 8'h0a, 1'b0, 8'h15};
        rows[5] = {8'h0b, 8'h8a, 1'b0, 8'h8a};
        rows[6] = {8'h0c, 8'haa, 1'b0, 8'h00};
        rows[7] = {8'h0f, 8'h5a, 1'b0, 8'h00};
        rows[8] = {8'h30, 8'hff, 1'b0, 8'h00};
        repeat (20) @(negedge clk);
        arst_n = 1'b1;
        repeat (6) @(negedge clk);
        check_read(`CHG_CFG_OFFSET, 8'h30);
        check_read(`LINE_POL_OFFSET, 8'h15);
        cmp(vdo, `VDO_RESET);
        cmp({28'h0, pwr}, 32'h5);
        for (i = 0; i < 9; i = i + 1) begin
            loader.wr(rows[i][24:17], rows[i][16:9], rows[i][8]);
            check_read(rows[i][24:17], rows[i][7:0]);
        end
        cmp(vdo, 32'h5a001caa);
        cmp({17'h0, p_dp_out, p_dm_out, p_oe}, {17'h0, 5'h15, 5'h0a, 5'h13});
        cmp({22'h0, c_dp_in, c_dm_in}, {22'h0, 5'h15, 5'h0a});
        cmp({24'h0, mode}, 32'hcf);
        up = 1'b1;
        repeat (3) @(negedge clk);
        cmp({24'h0, mode}, 32'h45);
        // eeprom mode: only loader-sourced writes may move the polarity bit
        up = 1'b0;
        ee_mode = 1'b1;
        loader.wr(`CHG_CFG_OFFSET, 8'h2e, 1'b1);
        check_read(`CHG_CFG_OFFSET, 8'h3e);
        cmp({24'h0, mode}, 32'h8a);
        cmp({31'h0, acp3}, 32'h1);
        cmp({24'h0, spare, pol, hicur, autodis, acp3}, 32'h3f);
        loader.wr(`CHG_CFG_OFFSET, 8'h00, 1'b0);
        check_read(`CHG_CFG_OFFSET, 8'h30);
        // locked select follows the otp default as soon as it moves
        otp_hicur = 1'b0;
        check_read(`CHG_CFG_OFFSET, 8'h20);
        otp_hicur = 1'b1;
        // second reset with the strap low: capture follows the new level
        strap = 1'b0;
        arst_n = 1'b0;
        repeat (2) @(negedge clk);
        arst_n = 1'b1;
        repeat (6) @(negedge clk);
        check_read(`CHG_CFG_OFFSET, 8'h10);
        cmp({27'h0, pol, pwr}, 32'h0a);
        cmp(vdo, `VDO_RESET);
        finish_test;
    end
endmodule
